/* File: hw/ssr_register_bank.sv */
`timescale 1ns/1ps
`include "ssr_consts.svh"
module ssr_register_bank #(
  parameter logic [7:0] CHIP_ID = 8'h3c // arbitrary id value
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [6:0] i_addr,
  input wire ssr_pkg::ssr_byte_t i_wdata,
  output ssr_pkg::ssr_byte_t o_rdata,
  output ssr_pkg::ssr_page_t o_page,
  input wire ssr_pkg::ssr_byte_t i_in_fail_evt,
  input wire ssr_pkg::ssr_byte_t i_loop_evt,
  input wire ssr_pkg::ssr_byte_t i_mon_fail_hi_evt,
  input wire ssr_pkg::ssr_byte_t i_mon_fail_lo_evt,
  input wire logic i_otp_valid,
  input wire ssr_pkg::ssr_byte_t i_otp_mon_mask_hi,
  input wire ssr_pkg::ssr_byte_t i_otp_mon_mask_lo,
  input wire ssr_pkg::ssr_byte_t i_otp_in_config,
  input wire ssr_pkg::ssr_byte_t i_otp_soak_disq,
  input wire ssr_pkg::ssr_byte_t i_otp_soak_qual,
  input wire ssr_pkg::ssr_word_t i_otp_base_freq,
  output ssr_pkg::ssr_byte_t o_in_fail_mask,
  output ssr_pkg::ssr_byte_t o_loop_mask,
  output ssr_pkg::ssr_byte_t o_mon_mask_hi,
  output ssr_pkg::ssr_byte_t o_mon_mask_lo,
  output ssr_pkg::ssr_byte_t o_in_config,
  output ssr_pkg::ssr_byte_t o_soak_disq,
  output ssr_pkg::ssr_byte_t o_soak_qual,
  output logic o_freeze,
  output ssr_pkg::ssr_word_t o_base_freq
);
  import ssr_pkg::*;

  ssr_byte_t chip_chip_identification, chip_id_next;
  ssr_byte_t in_fail_stat_reg;
  ssr_byte_t loop_stat_reg;
  ssr_byte_t mon_fail_hi_reg;
  ssr_byte_t mon_fail_lo_reg;
  ssr_byte_t in_fail_mask_reg, in_fail_mask_next;
  ssr_byte_t loop_mask_reg, loop_mask_next;
  ssr_byte_t mon_mask_hi_reg, mon_mask_hi_next;
  ssr_byte_t mon_mask_lo_reg, mon_mask_lo_next;
  ssr_byte_t in_config_reg, in_config_next;
  ssr_byte_t soak_disq_reg, soak_disq_next;
  ssr_byte_t soak_qual_reg, soak_qual_next;
  ssr_byte_t freeze_reg, freeze_next;
  ssr_word_t base_freq_reg, base_freq_next;
  ssr_byte_t base_msb_hold_reg, base_msb_hold_next;
  ssr_page_t page_reg, page_next;
  logic otp_done_reg, otp_done_next;
  ssr_byte_t rdata_reg, rdata_next;
  logic frozen;
  logic lower_wr;

  assign frozen = freeze_reg[`SSR_FREEZE_BIT];
  assign lower_wr = i_wr_en && (page_reg == SSR_PAGE_LOWER);

  always_comb begin
    chip_id_next = chip_chip_identification;
    in_fail_mask_next = in_fail_mask_reg;
    loop_mask_next = loop_mask_reg;
    mon_mask_hi_next = mon_mask_hi_reg;
    mon_mask_lo_next = mon_mask_lo_reg;
    in_config_next = in_config_reg;
    soak_disq_next = soak_disq_reg;
    soak_qual_next = soak_qual_reg;
    freeze_next = freeze_reg;
    base_freq_next = base_freq_reg;
    base_msb_hold_next = base_msb_hold_reg;
    otp_done_next = 1'b1;
    if (lower_wr) begin
      case (i_addr)
        // [R7] id write held until reset
        `SSR_ADDR_CHIP_ID: begin
          chip_id_next = i_wdata;
        end
        // [R11] separate event masks
        `SSR_ADDR_IN_FAIL_MASK: begin
          in_fail_mask_next = i_wdata;
        end
        `SSR_ADDR_LOOP_MASK: begin
          loop_mask_next = i_wdata;
        end
        // [R13] per-pair failure masks
        `SSR_ADDR_MON_MASK_HI: begin
          mon_mask_hi_next = i_wdata;
        end
        `SSR_ADDR_MON_MASK_LO: begin
          mon_mask_lo_next = i_wdata;
        end
        // [R12] signalling selection
        `SSR_ADDR_IN_CONFIG: begin
          in_config_next = i_wdata;
        end
        `SSR_ADDR_SOAK_DISQ: begin
          soak_disq_next = i_wdata;
        end
        `SSR_ADDR_SOAK_QUAL: begin
          soak_qual_next = i_wdata;
        end
        `SSR_ADDR_FREEZE: begin
          freeze_next = i_wdata;
        end
        // [R14] msb held, applied on lsb
        `SSR_ADDR_BASE_FREQ_MSB: begin
          base_msb_hold_next = i_wdata;
        end
        // [R10] 16-bit base frequency
        `SSR_ADDR_BASE_FREQ_LSB: begin
          base_freq_next = {base_msb_hold_reg, i_wdata};
        end
        default: begin
          chip_id_next = chip_chip_identification;
        end
      endcase
    end
    // [R8] programmed image replaces defaults
    if (!otp_done_reg && i_otp_valid) begin
      mon_mask_hi_next = i_otp_mon_mask_hi;
      mon_mask_lo_next = i_otp_mon_mask_lo;
      in_config_next = i_otp_in_config;
      soak_disq_next = i_otp_soak_disq;
      soak_qual_next = i_otp_soak_qual;
      base_freq_next = i_otp_base_freq;
      base_msb_hold_next = i_otp_base_freq[15:8];
    end
  end

  // [R13] latched failure and event status
  ssr_latched_status #(.WIDTH(8)) u_in_fail_stat (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_evt(i_in_fail_evt),
    .i_wr(lower_wr && i_addr == `SSR_ADDR_IN_FAIL_STAT),
    .i_wdata(i_wdata),
    .i_hold(frozen),
    .o_value(in_fail_stat_reg)
  );

  ssr_latched_status #(.WIDTH(8)) u_loop_stat (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_evt(i_loop_evt),
    .i_wr(lower_wr && i_addr == `SSR_ADDR_LOOP_STAT),
    .i_wdata(i_wdata),
    .i_hold(frozen),
    .o_value(loop_stat_reg)
  );

  ssr_latched_status #(.WIDTH(8)) u_mon_fail_hi (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_evt(i_mon_fail_hi_evt),
    .i_wr(lower_wr && i_addr == `SSR_ADDR_MON_FAIL_HI),
    .i_wdata(i_wdata),
    .i_hold(frozen),
    .o_value(mon_fail_hi_reg)
  );

  ssr_latched_status #(.WIDTH(8)) u_mon_fail_lo (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_evt(i_mon_fail_lo_evt),
    .i_wr(lower_wr && i_addr == `SSR_ADDR_MON_FAIL_LO),
    .i_wdata(i_wdata),
    .i_hold(frozen),
    .o_value(mon_fail_lo_reg)
  );

  // read path, one cycle latency
  always_comb begin
    rdata_next = rdata_reg;
    if (i_rd_en) begin
      rdata_next = `SSR_RST_ZERO;
      if (i_addr == `SSR_ADDR_PAGE) begin
        rdata_next = {7'h00, page_reg};
      end else if (page_reg == SSR_PAGE_LOWER) begin
        case (i_addr)
          `SSR_ADDR_CHIP_ID: rdata_next = chip_chip_identification;
          `SSR_ADDR_IN_FAIL_STAT: rdata_next = in_fail_stat_reg;
          `SSR_ADDR_LOOP_STAT: rdata_next = loop_stat_reg;
          `SSR_ADDR_IN_FAIL_MASK: rdata_next = in_fail_mask_reg;
          `SSR_ADDR_LOOP_MASK: rdata_next = loop_mask_reg;
          `SSR_ADDR_MON_FAIL_HI: rdata_next = mon_fail_hi_reg;
          `SSR_ADDR_MON_FAIL_LO: rdata_next = mon_fail_lo_reg;
          `SSR_ADDR_MON_MASK_HI: rdata_next = mon_mask_hi_reg;
          `SSR_ADDR_MON_MASK_LO: rdata_next = mon_mask_lo_reg;
          `SSR_ADDR_IN_CONFIG: rdata_next = in_config_reg;
          `SSR_ADDR_SOAK_DISQ: rdata_next = soak_disq_reg;
          `SSR_ADDR_SOAK_QUAL: rdata_next = soak_qual_reg;
          `SSR_ADDR_FREEZE: rdata_next = freeze_reg;
          `SSR_ADDR_BASE_FREQ_MSB: rdata_next = base_freq_reg[15:8];
          `SSR_ADDR_BASE_FREQ_LSB: rdata_next = base_freq_reg[7:0];
          default: rdata_next = `SSR_RST_ZERO;
        endcase
      end
    end
  end

  // [R9] reset defaults
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      chip_chip_identification <= CHIP_ID;
      in_fail_mask_reg <= `SSR_RST_ZERO;
      loop_mask_reg <= `SSR_RST_ZERO;
      mon_mask_hi_reg <= `SSR_RST_MON_MASK;
      mon_mask_lo_reg <= `SSR_RST_MON_MASK;
      in_config_reg <= `SSR_RST_IN_CONFIG;
      soak_disq_reg <= `SSR_RST_SOAK_DISQ;
      soak_qual_reg <= `SSR_RST_SOAK_QUAL;
      freeze_reg <= `SSR_RST_ZERO;
      base_freq_reg <= `SSR_RST_BASE_FREQ;
      base_msb_hold_reg <= 8'(`SSR_RST_BASE_FREQ >> 8);
      otp_done_reg <= 1'b0;
    end else begin
      chip_chip_identification <= chip_id_next;
      in_fail_mask_reg <= in_fail_mask_next;
      loop_mask_reg <= loop_mask_next;
      mon_mask_hi_reg <= mon_mask_hi_next;
      mon_mask_lo_reg <= mon_mask_lo_next;
      in_config_reg <= in_config_next;
      soak_disq_reg <= soak_disq_next;
      soak_qual_reg <= soak_qual_next;
      freeze_reg <= freeze_next;
      base_freq_reg <= base_freq_next;
      base_msb_hold_reg <= base_msb_hold_next;
      otp_done_reg <= otp_done_next;
    end
  end

  // [R15] page toggle on 0x01, from either page
  always_comb begin
    page_next = page_reg;
    if (i_wr_en && i_addr == `SSR_ADDR_PAGE && i_wdata == `SSR_PAGE_TOGGLE) begin
      page_next = (page_reg == SSR_PAGE_LOWER) ? SSR_PAGE_UPPER : SSR_PAGE_LOWER;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      page_reg <= SSR_PAGE_LOWER;
    end else begin
      page_reg <= page_next;
    end
  end

  // read data register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= `SSR_RST_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_page = page_reg;
  assign o_in_fail_mask = in_fail_mask_reg;
  assign o_loop_mask = loop_mask_reg;
  assign o_mon_mask_hi = mon_mask_hi_reg;
  assign o_mon_mask_lo = mon_mask_lo_reg;
  assign o_in_config = in_config_reg;
  assign o_soak_disq = soak_disq_reg;
  assign o_soak_qual = soak_qual_reg;
  assign o_freeze = frozen;
  assign o_base_freq = base_freq_reg;
endmodule

// one latched status register, set by events, written by the host
module ssr_latched_status #(
  parameter int WIDTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_evt,
  input wire logic i_wr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic i_hold,
  output logic [WIDTH-1:0] o_value
);
  logic [WIDTH-1:0] value_reg, value_next;

  // host write stores the byte
  always_comb begin
    value_next = value_reg;
    if (i_wr) begin
      value_next = i_wdata;
    end
    // [R6] sticky set, never self-clears
    // [R5] freeze blocks internal updates
    if (!i_hold) begin
      value_next = value_next | i_evt;
    end
  end

  // [R9] status clears to zero
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      value_reg <= WIDTH'(`SSR_RST_ZERO);
    end else begin
      value_reg <= value_next;
    end
  end

  assign o_value = value_reg;
endmodule

/* File: shared/ssr_consts.svh */
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
// What this block does
// [R1] host sets freeze to 0x01 before config writes, 0x00 after them
// [R2] auto-to-forced mode change: freeze, write, wait 5 ms, unfreeze
// [R3] host spaces same-register writes 5 ms, except freeze and page registers
// [R4] latched read: freeze, write zeros, unfreeze, wait 5 ms, read
// [R5] while freeze engaged, internal events cannot update latched status registers
// [R6] latched status bits set on event and hold until host clears them
// [R7] identification register writable, value held until reset, affects nothing
// [R8] programmed one-time configuration replaces listed defaults at power-up
// [R9] defaults: masks 0x66, soak 0xaa/0x55, status, event masks, freeze zero
// [R10] input 0 base frequency is 16-bit hertz over two bytes, reset 0x9c40
// [R11] separate input-failure and loop event masks, both reset to zero
// [R12] input signalling config selects differential or single-ended, reset 0x10
// [R13] monitor failures latched in high and low pair registers, each masked
// [R14] multi-byte values go msb first, applied when lsb byte written
// [R15] writing 0x01 to page-select toggles lower and upper register page

`define SSR_ADDR_CHIP_ID 7'h00
`define SSR_ADDR_IN_FAIL_STAT 7'h02
`define SSR_ADDR_LOOP_STAT 7'h03
`define SSR_ADDR_IN_FAIL_MASK 7'h04
`define SSR_ADDR_LOOP_MASK 7'h05
`define SSR_ADDR_MON_FAIL_HI 7'h06
`define SSR_ADDR_MON_FAIL_LO 7'h07
`define SSR_ADDR_MON_MASK_HI 7'h08
`define SSR_ADDR_MON_MASK_LO 7'h09
`define SSR_ADDR_IN_CONFIG 7'h0a
`define SSR_ADDR_SOAK_DISQ 7'h0b
`define SSR_ADDR_SOAK_QUAL 7'h0c
`define SSR_ADDR_FREEZE 7'h0d
`define SSR_ADDR_BASE_FREQ_MSB 7'h10
`define SSR_ADDR_BASE_FREQ_LSB 7'h11
`define SSR_ADDR_PAGE 7'h7f

`define SSR_RST_ZERO 8'h00
`define SSR_RST_MON_MASK 8'h66
`define SSR_RST_IN_CONFIG 8'h10
`define SSR_RST_SOAK_DISQ 8'haa
`define SSR_RST_SOAK_QUAL 8'h55
`define SSR_RST_BASE_FREQ 16'h9c40
`define SSR_PAGE_TOGGLE 8'h01
`define SSR_FREEZE_BIT 0
`endif

/* File: shared/ssr_pkg.sv */
package ssr_pkg;
  typedef enum logic {
    SSR_PAGE_LOWER = 1'b0,
    SSR_PAGE_UPPER = 1'b1
  } ssr_page_t;
  typedef logic [7:0] ssr_byte_t;
  typedef logic [15:0] ssr_word_t;
endpackage

/* File: test/ssr_host_model.sv */
`timescale 1ns/1ps
module ssr_host_model #(
  parameter int GAP = 4
) (
  input wire logic i_ref_clk,
  input wire ssr_pkg::ssr_byte_t i_rdata,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [6:0] o_addr,
  output ssr_pkg::ssr_byte_t o_wdata
);
  import ssr_pkg::*;
  initial begin
    o_wr_en = 1'h0;
    o_rd_en = 1'h0;
    o_addr = 7'h00;
    o_wdata = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input ssr_byte_t d);
    @(posedge i_ref_clk);
    o_wr_en <= 1'h1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_ref_clk);
    o_wr_en <= 1'h0;
    o_addr <= ~a;
    o_wdata <= ~d;
    @(negedge i_ref_clk);
    if (a != 7'h0d && a != 7'h7f) repeat (GAP) @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [6:0] a, output ssr_byte_t d);
    @(posedge i_ref_clk);
    o_rd_en <= 1'h1;
    o_addr <= a;
    @(posedge i_ref_clk);
    o_rd_en <= 1'h0;
    o_addr <= ~a;
    @(negedge i_ref_clk);
    d = i_rdata;
  endtask
  task automatic freeze(input logic on);
    wr(7'h0d, {7'h00, on});
    if (!on) repeat (GAP) @(posedge i_ref_clk);
  endtask
endmodule

/* File: test/ssr_props.sv */
`timescale 1ns/1ps
module ssr_props (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [6:0] i_addr,
  input wire ssr_pkg::ssr_byte_t i_wdata,
  input wire ssr_pkg::ssr_byte_t o_rdata,
  input wire ssr_pkg::ssr_page_t o_page,
  input wire ssr_pkg::ssr_byte_t o_in_fail_mask,
  input wire ssr_pkg::ssr_byte_t o_mon_mask_hi,
  input wire ssr_pkg::ssr_byte_t o_in_config,
  input wire logic o_freeze,
  input wire ssr_pkg::ssr_word_t o_base_freq
);
  import ssr_pkg::*;
  logic wl;
  assign wl = i_wr_en && o_page == SSR_PAGE_LOWER;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  chk_reset_values:
  assert property ($rose(i_rst_b) |-> o_mon_mask_hi == 8'h66 && o_in_config == 8'h10
    && o_base_freq == 16'h9c40 && !o_freeze) else $error("bad reset value");
  chk_freeze_write:
  assert property (wl && i_addr == 7'h0d |=> o_freeze == $past(i_wdata[0]))
    else $error("bad freeze bit");
  chk_mask_write:
  assert property (wl && i_addr == 7'h04 |=> o_in_fail_mask == $past(i_wdata))
    else $error("bad event mask");
  chk_msb_held:
  assert property (wl && i_addr == 7'h10 |=> $stable(o_base_freq))
    else $error("msb applied early");
  chk_lsb_applies:
  assert property (wl && i_addr == 7'h11 |=> o_base_freq[7:0] == $past(i_wdata))
    else $error("lsb not applied");
  chk_page_toggle:
  assert property (i_wr_en && i_addr == 7'h7f && i_wdata == 8'h01 |=> o_page != $past(o_page))
    else $error("page not toggled");
  chk_page_keep:
  assert property (i_wr_en && i_addr == 7'h7f && i_wdata != 8'h01 |=> $stable(o_page))
    else $error("page moved");
  chk_upper_blocks:
  assert property (i_wr_en && o_page == SSR_PAGE_UPPER && i_addr != 7'h7f
    |=> $stable(o_in_config)) else $error("upper write landed");
  chk_upper_reads:
  assert property (i_rd_en && o_page == SSR_PAGE_UPPER && i_addr != 7'h7f
    |=> o_rdata == 8'h00) else $error("upper read not zero");
  cov_toggle: cover property (i_wr_en && i_addr == 7'h7f && i_wdata == 8'h01);
  cov_lsb: cover property (wl && i_addr == 7'h11);
  cov_frozen: cover property (o_freeze && i_wr_en);
endmodule

/* File: test/tb_sticky_status_register_bank.sv */
`timescale 1ns/1ps
module tb_sticky_status_register_bank;
  import ssr_pkg::*;
  // arbitrary id value
  localparam ssr_byte_t ID = 8'h5a;
  localparam ssr_byte_t EX [16] = '{ID, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h66, 8'h66, 8'h10, 8'haa, 8'h55, 8'h00, 8'h00, 8'h00};
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic otp_v = 1'h0;
  logic wr, rd, frz;
  logic [6:0] addr;
  ssr_byte_t wd, rdat, fmask, cfg, mhi, lmask, mlo, sdq, sql;
  ssr_byte_t otp = 8'h00;
  ssr_byte_t ev [4] = '{default: 8'h00};
  ssr_page_t pg;
  ssr_word_t bf;
  int n_errors = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  ssr_register_bank #(.CHIP_ID(ID)) DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_wr_en(wr),
    .i_rd_en(rd), .i_addr(addr), .i_wdata(wd), .o_rdata(rdat), .o_page(pg),
    .i_in_fail_evt(ev[0]), .i_loop_evt(ev[1]), .i_mon_fail_hi_evt(ev[2]),
    .i_mon_fail_lo_evt(ev[3]), .i_otp_valid(otp_v), .i_otp_mon_mask_hi(otp),
    .i_otp_mon_mask_lo(otp), .i_otp_in_config(otp), .i_otp_soak_disq(otp),
    .i_otp_soak_qual(otp), .i_otp_base_freq({otp, otp}), .o_in_fail_mask(fmask),
    .o_loop_mask(lmask), .o_mon_mask_hi(mhi), .o_mon_mask_lo(mlo), .o_in_config(cfg),
    .o_soak_disq(sdq), .o_soak_qual(sql), .o_freeze(frz), .o_base_freq(bf));
  ssr_host_model HOST (.i_ref_clk(clk), .i_rdata(rdat), .o_wr_en(wr), .o_rd_en(rd),
    .o_addr(addr), .o_wdata(wd));
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input ssr_byte_t e);
    ssr_byte_t d;
    HOST.rd(a, d);
    cmp(16'(d), 16'(e));
  endtask
  task automatic t_defaults;
    for (int i = 0; i < 16; i++) begin
      rchk(7'(i), EX[i]);
    end
    rchk(7'h10, 8'h9c);
    rchk(7'h11, 8'h40);
  endtask
  task automatic t_rw;
    logic [6:0] al [8] = '{7'h00, 7'h04, 7'h05, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c};
    HOST.freeze(1'h1);
    foreach (al[i]) begin
      HOST.wr(al[i], ~EX[al[i]]);
      rchk(al[i], ~EX[al[i]]);
    end
    repeat (4) @(posedge clk);
    HOST.freeze(1'h0);
    cmp(16'(fmask), 16'h00ff);
    cmp(16'(lmask), 16'h00ff);
    cmp(16'(mhi), 16'h0099);
    cmp(16'(mlo), 16'h0099);
    cmp(16'(cfg), 16'h00ef);
    cmp(16'(sdq), 16'h0055);
    cmp(16'(sql), 16'h00aa);
  endtask
  task automatic t_latch;
    logic [6:0] st [4] = '{7'h02, 7'h03, 7'h06, 7'h07};
    @(posedge clk);
    ev <= '{8'h05, 8'h81, 8'h30, 8'h03};
    @(posedge clk);
    ev <= '{default: 8'h00};
    rchk(7'h02, 8'h05);
    rchk(7'h03, 8'h81);
    rchk(7'h06, 8'h30);
    rchk(7'h07, 8'h03);
    HOST.freeze(1'h1);
    cmp(16'(frz), 16'h0001);
    @(posedge clk);
    ev <= '{default: 8'hff};
    foreach (st[i]) HOST.wr(st[i], 8'h00);
    foreach (st[i]) rchk(st[i], 8'h00);
    @(posedge clk);
    ev <= '{default: 8'h00};
    HOST.freeze(1'h0);
    cmp(16'(frz), 16'h0000);
    rchk(7'h02, 8'h00);
  endtask
  task automatic t_freq;
    HOST.wr(7'h10, 8'h12);
    cmp(bf, 16'h9c40);
    HOST.wr(7'h11, 8'h34);
    cmp(bf, 16'h1234);
  endtask
  task automatic t_page;
    HOST.wr(7'h7f, 8'h02);
    cmp(16'(pg), 16'h0000);
    HOST.wr(7'h7f, 8'h01);
    cmp(16'(pg), 16'h0001);
    HOST.wr(7'h0a, 8'h00);
    rchk(7'h0a, 8'h00);
    rchk(7'h7f, 8'h01);
    HOST.wr(7'h7f, 8'h01);
    rchk(7'h0a, ~EX[10]);
  endtask
  task automatic t_otp;
    @(posedge clk);
    otp_v <= 1'h1;
    otp <= 8'h3e;
    rst_b <= 1'h0;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    repeat (2) @(negedge clk);
    cmp(16'(mhi), 16'h003e);
    cmp(bf, 16'h3e3e);
    cmp(16'(cfg), 16'h003e);
    cmp(16'(fmask), 16'h0000);
    cmp(16'(lmask), 16'h0000);
  endtask
  task automatic results;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    repeat (2) @(posedge clk);
    t_defaults;
    t_rw;
    t_latch;
    t_freq;
    t_page;
    t_otp;
    results;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("mismatch %0t timeout", $time);
    results;
  end
endmodule
bind ssr_register_bank ssr_props CHK (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
  .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_page(o_page), .o_in_fail_mask(o_in_fail_mask),
  .o_mon_mask_hi(o_mon_mask_hi), .o_in_config(o_in_config), .o_freeze(o_freeze),
  .o_base_freq(o_base_freq));
